// ===== include/eio_pkg.sv
// Constants for the eight-bit I/O port: register map, reset values and pin routing.
package eio_pkg;

  // ------------------------------------------------------------
  // Register map on the data-memory port
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;                 // Address width of the port.
  localparam logic [2:0] ADDR_DATA   = 3'h0;          // Port data latch / pin levels.
  localparam logic [2:0] ADDR_DIR    = 3'h1;          // Direction, 1 = input.
  localparam logic [2:0] ADDR_PULLUP = 3'h2;          // Pull-up enables.
  localparam logic [2:0] ADDR_WAKE   = 3'h3;          // Wake-up enables.
  localparam logic [2:0] ADDR_FUNC   = 3'h4;          // Pin function select.
  localparam logic [2:0] ADDR_REMAP  = 3'h5;          // Pin remap select.

  // ------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DATA   = 8'hff;
  localparam logic [7:0] RST_DIR    = 8'hff;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_WAKE   = 8'h00;
  localparam logic [7:0] RST_FUNC   = 8'h00;
  localparam logic [7:0] RST_REMAP  = 8'h00;
  localparam logic [7:0] FUNC_MASK  = 8'h55;          // Only even bits exist.
  localparam logic [7:0] REMAP_MASK = 8'h33;          // Bits 5,4,1,0 exist.

  // ------------------------------------------------------------
  // Field positions and pin numbers
  // ------------------------------------------------------------
  localparam int unsigned SHARE_SEL_BIT6 = 6;         // Routes pin 5.
  localparam int unsigned SHARE_SEL_BIT4 = 4;         // Routes pin 2.
  localparam int unsigned SHARE_SEL_BIT2 = 2;         // Routes pin 1.
  localparam int unsigned SHARE_SEL_BIT0 = 0;         // Routes pin 0.
  localparam int unsigned PIN_SHARE6 = 5;
  localparam int unsigned PIN_SHARE4 = 2;
  localparam int unsigned PIN_SHARE2 = 1;
  localparam int unsigned PIN_SHARE0 = 0;
  localparam int unsigned IRQ_PIN_REMAP_LO = 0;
  localparam int unsigned IRQ_PIN_REMAP_HI = 1;
  localparam int unsigned CAPT_REMAP_BIT  = 4;        // 0: pin 6, 1: pin 0.
  localparam int unsigned TCLK_REMAP_BIT  = 5;        // 0: pin 7, 1: pin 6.
  localparam logic [2:0] IRQ_PIN_SEL0 = 3'h5;
  localparam logic [2:0] IRQ_PIN_SEL1 = 3'h2;
  localparam logic [2:0] IRQ_PIN_SEL2 = 3'h3;
  localparam logic [2:0] IRQ_PIN_SEL3 = 3'h7;
  localparam logic [2:0] CAPT_PIN_DEF = 3'h6;
  localparam logic [2:0] CAPT_PIN_ALT = 3'h0;
  localparam logic [2:0] TCLK_PIN_DEF = 3'h7;
  localparam logic [2:0] TCLK_PIN_ALT = 3'h6;

endpackage : eio_pkg

// ===== rtl/eio_port.sv
// Eight-bit bidirectional I/O port with pin sharing, wake-up and register access.
//
// Operation
// - Input pins read live synchronised level.
// - Output latch holds until next write.
// - Direction bit one input, zero push-pull.
// - Output pins read back latch content.
// - Pull-up acts only on input pins.
// - Enabled falling edge wakes sleeping device.
// - Bit six routes pin five inverted timer.
// - Bit four routes pin two timer.
// - Bit two routes pin one inverted timer.
// - Odd select bits ignore writes, read zero.
// - Resets restore data, direction, pull, wake.
// - Remap field picks external interrupt pin.
`timescale 1ns/1ps

module eio_port (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        SYS_RESET,
  input  wire logic        SLEEP,
  input  wire logic [2:0]  WR_ADDR,
  input  wire logic        WR_EN,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic [2:0]  RD_ADDR,
  input  wire logic        RD_EN,
  input  wire logic        TIMER_OUTPUT,
  input  wire logic        TIMER_OUTPUT_INVERTED,
  input  wire logic [7:0]  PA_IN,
  output logic      [7:0]  PA_OUT,
  output logic      [7:0]  PA_OE,
  output logic      [7:0]  PA_PULLUP,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID,
  output logic             WAKE,
  output logic             EXT_IRQ_PIN,
  output logic             TIMER_CAPTURE_INPUT,
  output logic             TIMER_CLK_PIN
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] data_q, data_d;       // Output data latch.
  logic [7:0] dir_q, dir_d;         // Direction, 1 = input.
  logic [7:0] pu_q, pu_d;           // Pull-up enables.
  logic [7:0] wake_q, wake_d;       // Wake-up enables.
  logic [7:0] func_q, func_d;       // Pin function select.
  logic [7:0] remap_q, remap_d;     // Pin remap select.
  logic [7:0] pin_s1_q, pin_s2_q;   // Two-stage synchroniser.
  logic [7:0] pin_prev_q;           // Last synchronised level, for edges.
  logic [7:0] share_en;             // Pin handed to the timer.
  logic [7:0] share_val;            // Timer level for shared pins.
  logic [7:0] out_d, oe_d, pull_d;  // Next pin drive values.
  logic [7:0] rd_data_d;
  logic       rd_valid_d, wake_pulse_d, irq_d, capt_d, tclk_d;
  logic [2:0] irq_sel;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // A soft reset covers watchdog timeout in normal mode and the reset
  // pin; a watchdog timeout in halt must not raise it, so state holds.
  always_comb
  begin
    data_d  = data_q;
    dir_d   = dir_q;
    pu_d    = pu_q;
    wake_d  = wake_q;
    func_d  = func_q;
    remap_d = remap_q;
    if (SYS_RESET)
    begin
      data_d  = eio_pkg::RST_DATA;
      dir_d   = eio_pkg::RST_DIR;
      pu_d    = eio_pkg::RST_PULLUP;
      wake_d  = eio_pkg::RST_WAKE;
      func_d  = eio_pkg::RST_FUNC;
      remap_d = eio_pkg::RST_REMAP;
    end
    else if (WR_EN)
    begin
      case (WR_ADDR)
        eio_pkg::ADDR_DATA:   data_d  = WR_DATA;
        eio_pkg::ADDR_DIR:    dir_d   = WR_DATA;
        eio_pkg::ADDR_PULLUP: pu_d    = WR_DATA;
        eio_pkg::ADDR_WAKE:   wake_d  = WR_DATA;
        eio_pkg::ADDR_FUNC:   func_d  = WR_DATA & eio_pkg::FUNC_MASK;
        eio_pkg::ADDR_REMAP:  remap_d = WR_DATA & eio_pkg::REMAP_MASK;
        default:              data_d  = data_q;      // Unmapped writes are dropped.
      endcase
    end
  end

  // Register bank flops; power-on reset sets the documented values.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      data_q  <= eio_pkg::RST_DATA;
      dir_q   <= eio_pkg::RST_DIR;
      pu_q    <= eio_pkg::RST_PULLUP;
      wake_q  <= eio_pkg::RST_WAKE;
      func_q  <= eio_pkg::RST_FUNC;
      remap_q <= eio_pkg::RST_REMAP;
    end
    else
    begin
      data_q  <= data_d;
      dir_q   <= dir_d;
      pu_q    <= pu_d;
      wake_q  <= wake_d;
      func_q  <= func_d;
      remap_q <= remap_d;
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Pins are asynchronous; only the second stage and the edge copy behind it (pin_prev_q) are ever looked at.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pin_s1_q   <= 8'hff;
      pin_s2_q   <= 8'hff;
      pin_prev_q <= 8'hff;
    end
    else
    begin
      pin_s1_q   <= PA_IN;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // ------------------------------------------------------------
  // Pin routing and drive
  // ------------------------------------------------------------
  // Collect which pins the timer owns and what level it wants there.
  always_comb
  begin
    share_en  = 8'h00;
    share_val = 8'h00;
    share_en[eio_pkg::PIN_SHARE6]  = func_q[eio_pkg::SHARE_SEL_BIT6];
    share_val[eio_pkg::PIN_SHARE6] = TIMER_OUTPUT_INVERTED;
    share_en[eio_pkg::PIN_SHARE4]  = func_q[eio_pkg::SHARE_SEL_BIT4];
    share_val[eio_pkg::PIN_SHARE4] = TIMER_OUTPUT;
    share_en[eio_pkg::PIN_SHARE2]  = func_q[eio_pkg::SHARE_SEL_BIT2];
    share_val[eio_pkg::PIN_SHARE2] = TIMER_OUTPUT_INVERTED;
    share_en[eio_pkg::PIN_SHARE0]  = func_q[eio_pkg::SHARE_SEL_BIT0];
    share_val[eio_pkg::PIN_SHARE0] = TIMER_OUTPUT;
  end

  // Per pin: a timer-owned pin is always driven; otherwise the direction
  // bit decides, and the weak pull-up never fights an active driver.
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    assign out_d[i]  = share_en[i] ? share_val[i] : data_q[i];
    assign oe_d[i]   = share_en[i] | ~dir_q[i];
    assign pull_d[i] = pu_q[i] & dir_q[i] & ~share_en[i];
  end

  // ------------------------------------------------------------
  // Read path, wake-up and function inputs
  // ------------------------------------------------------------
  // Reads are answered one cycle later from a flop; no input latch is kept,
  // so input bits show the level synchronised at the read cycle.
  always_comb
  begin
    rd_valid_d = RD_EN;
    rd_data_d  = RD_DATA;
    if (RD_EN)
    begin
      case (RD_ADDR)
        eio_pkg::ADDR_DATA:   rd_data_d = (dir_q & pin_s2_q) | (~dir_q & data_q);
        eio_pkg::ADDR_DIR:    rd_data_d = dir_q;
        eio_pkg::ADDR_PULLUP: rd_data_d = pu_q;
        eio_pkg::ADDR_WAKE:   rd_data_d = wake_q;
        eio_pkg::ADDR_FUNC:   rd_data_d = func_q;
        eio_pkg::ADDR_REMAP:  rd_data_d = remap_q;
        default:              rd_data_d = 8'h00;     // Unmapped reads give zero.
      endcase
    end
    // A falling edge on any enabled pin wakes the device while asleep.
    wake_pulse_d = SLEEP & |(wake_q & pin_prev_q & ~pin_s2_q);
    irq_sel = eio_pkg::IRQ_PIN_SEL0;
    case ({remap_q[eio_pkg::IRQ_PIN_REMAP_HI], remap_q[eio_pkg::IRQ_PIN_REMAP_LO]})
      2'h0:    irq_sel = eio_pkg::IRQ_PIN_SEL0;
      2'h1:    irq_sel = eio_pkg::IRQ_PIN_SEL1;
      2'h2:    irq_sel = eio_pkg::IRQ_PIN_SEL2;
      default: irq_sel = eio_pkg::IRQ_PIN_SEL3;
    endcase
    irq_d  = pin_s2_q[irq_sel];
    capt_d = remap_q[eio_pkg::CAPT_REMAP_BIT] ? pin_s2_q[eio_pkg::CAPT_PIN_ALT]
                                              : pin_s2_q[eio_pkg::CAPT_PIN_DEF];
    tclk_d = remap_q[eio_pkg::TCLK_REMAP_BIT] ? pin_s2_q[eio_pkg::TCLK_PIN_ALT]
                                              : pin_s2_q[eio_pkg::TCLK_PIN_DEF];
  end

  // Output flops; after reset every pin is an undriven input.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PA_OUT              <= 8'hff;
      PA_OE               <= 8'h00;
      PA_PULLUP           <= 8'h00;
      RD_DATA             <= 8'h00;
      RD_VALID            <= 1'b0;
      WAKE                <= 1'b0;
      EXT_IRQ_PIN         <= 1'b1;
      TIMER_CAPTURE_INPUT <= 1'b1;
      TIMER_CLK_PIN       <= 1'b1;
    end
    else
    begin
      PA_OUT              <= out_d;
      PA_OE               <= oe_d;
      PA_PULLUP           <= pull_d;
      RD_DATA             <= rd_data_d;
      RD_VALID            <= rd_valid_d;
      WAKE                <= wake_pulse_d;
      EXT_IRQ_PIN         <= irq_d;
      TIMER_CAPTURE_INPUT <= capt_d;
      TIMER_CLK_PIN       <= tclk_d;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_data_read;
    RD_EN && RD_ADDR == eio_pkg::ADDR_DATA;
  endsequence
  sequence s_fall_seen;
    SLEEP && |(wake_q & pin_prev_q & ~pin_s2_q);
  endsequence

  a_read_input_live: assert property (s_data_read |=>
    (RD_DATA & $past(dir_q)) == ($past(pin_s2_q) & $past(dir_q)))
    else $error("input bit read does not show pin level");
  a_read_output_latch: assert property (s_data_read |=>
    (RD_DATA & ~$past(dir_q)) == ($past(data_q) & ~$past(dir_q)))
    else $error("output bit read does not show latch");
  a_latch_hold: assert property (!(WR_EN && WR_ADDR == eio_pkg::ADDR_DATA) && !SYS_RESET
    |=> $stable(data_q))
    else $error("output latch changed without a write");
  a_dir_oe: assert property (##1 PA_OE == (~$past(dir_q) | $past(share_en)))
    else $error("output enable does not follow direction");
  a_pullup_input: assert property (##1
    PA_PULLUP == ($past(pu_q) & $past(dir_q) & ~$past(share_en)))
    else $error("pull-up active on a driven pin");
  a_wake_edge: assert property (s_fall_seen |=> WAKE)
    else $error("enabled falling edge did not wake");
  a_wake_quiet: assert property (!SLEEP |=> !WAKE)
    else $error("wake raised while awake");
  a_share_six: assert property (func_q[6] |=>
    PA_OE[5] && PA_OUT[5] == $past(TIMER_OUTPUT_INVERTED))
    else $error("pin 5 not routed to inverted timer");
  a_share_four: assert property (func_q[4] |=>
    PA_OE[2] && PA_OUT[2] == $past(TIMER_OUTPUT))
    else $error("pin 2 not routed to timer");
  a_share_two: assert property (func_q[2] |=>
    PA_OE[1] && PA_OUT[1] == $past(TIMER_OUTPUT_INVERTED))
    else $error("pin 1 not routed to inverted timer");
  a_share_zero: assert property (!func_q[0] && !dir_q[0] |=>
    PA_OUT[0] == $past(data_q[0]))
    else $error("pin 0 not routed to port latch");
  a_func_odd_zero: assert property (WR_EN && WR_ADDR == eio_pkg::ADDR_FUNC && !SYS_RESET
    |=> func_q == ($past(WR_DATA) & 8'h55))
    else $error("odd select bits not ignored");
  a_soft_reset: assert property (SYS_RESET |=>
    data_q == 8'hff && dir_q == 8'hff && pu_q == 8'h00 && wake_q == 8'h00)
    else $error("soft reset values wrong");
  a_irq_remap: assert property (remap_q[1:0] == 2'h0 |=>
    EXT_IRQ_PIN == $past(pin_s2_q[5]))
    else $error("default interrupt pin not used");
  a_sync_depth: assert property (##2 pin_s2_q == $past(PA_IN, 2))
    else $error("pin synchroniser depth wrong");

endmodule : eio_port

// ===== test/eio_pin_model.sv
// Model of the switches and wiring that sit outside the eight port pins.
`timescale 1ns/1ps

module eio_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pullup,
  input  wire logic [7:0] sw_drive,
  input  wire logic [7:0] sw_level,
  output logic      [7:0] pa_in
);
  // A floating wire must not look stable, so it wanders every cycle.
  logic [7:0] float_q;

  // ----------------------------------------
  // Wire level from every driver on the pin.
  // ----------------------------------------
  always @(posedge clk)
  begin
    float_q <= (float_q === 8'h5a) ? 8'ha5 : 8'h5a;
  end

  // The port's own driver wins, then a switch, then the weak pull-up.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pa_oe[i])
        pa_in[i] = pa_out[i];
      else if (sw_drive[i])
        pa_in[i] = sw_level[i];
      else if (pa_pullup[i])
        pa_in[i] = 1'b1;
      else
        pa_in[i] = float_q[i];
    end
  end
endmodule : eio_pin_model

// ===== test/tb_eio_port.sv
// Self-checking bench for the eight-bit I/O port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_eio_port;
  logic       clk = 1'b0, arst_n = 1'b0, sys_reset = 1'b0, sleep = 1'b0;
  logic       wr_en = 1'b0, rd_en = 1'b0, t_out = 1'b0, t_inv = 1'b1;
  logic [2:0] wr_addr = 3'h0, rd_addr = 3'h0;
  logic [7:0] wr_data = 8'h00, sw_drive = 8'hff, sw_level = 8'hff;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu, rd_data;
  logic       rd_valid, wake, irq, capt, tclk;
  int         fail_count = 0, checked = 0, cycles = 0, c;
  int         pins [4] = '{5, 2, 3, 7};
  logic [7:0] rst_tab [7] = '{eio_pkg::RST_DATA, eio_pkg::RST_DIR, eio_pkg::RST_PULLUP,
    eio_pkg::RST_WAKE, eio_pkg::RST_FUNC, eio_pkg::RST_REMAP, 8'h00};

  eio_port dut_u (.CLK(clk), .ARST_N(arst_n), .SYS_RESET(sys_reset), .SLEEP(sleep),
    .WR_ADDR(wr_addr), .WR_EN(wr_en), .WR_DATA(wr_data), .RD_ADDR(rd_addr), .RD_EN(rd_en),
    .TIMER_OUTPUT(t_out), .TIMER_OUTPUT_INVERTED(t_inv), .PA_IN(pa_in), .PA_OUT(pa_out),
    .PA_OE(pa_oe), .PA_PULLUP(pa_pu), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WAKE(wake),
    .EXT_IRQ_PIN(irq), .TIMER_CAPTURE_INPUT(capt), .TIMER_CLK_PIN(tclk));

  eio_pin_model pins_u (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu),
    .sw_drive(sw_drive), .sw_level(sw_level), .pa_in(pa_in));

  // ----------------------------------------
  // Clock, hang guard and access tasks.
  // ----------------------------------------
  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = v;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  // Read answers one edge later, so the result is settled at the next falling edge.
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", e, rd_data)
  endtask : rchk

  task automatic cnt_wake(output int n);
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      // An unknown wake level counts as a pulse, so it cannot hide.
      if (wake !== 1'b0)
        n++;
    end
  endtask : cnt_wake

  task automatic reset_tab();
    for (int a = 0; a < 7; a++)
      rchk(3'(a), rst_tab[a]);
    `CHK("pa_oe", 8'h00, pa_oe)
  endtask : reset_tab

  task automatic close_out();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    reset_tab();
    wr(eio_pkg::ADDR_FUNC, 8'hff);
    wr(eio_pkg::ADDR_REMAP, 8'hff);
    rchk(eio_pkg::ADDR_FUNC, 8'h55);
    rchk(eio_pkg::ADDR_REMAP, 8'h33);
    wr(eio_pkg::ADDR_FUNC, 8'h00);
    wr(eio_pkg::ADDR_REMAP, 8'h00);
    // Upper nibble drives the latch, lower nibble reads switches.
    sw_level = 8'h03;
    wr(eio_pkg::ADDR_DATA, 8'h5a);
    wr(eio_pkg::ADDR_DIR, 8'h0f);
    repeat (2) @(negedge clk);
    `CHK("pa_oe", 8'hf0, pa_oe)
    rchk(eio_pkg::ADDR_DATA, 8'h53);
    wr(eio_pkg::ADDR_PULLUP, 8'hff);
    repeat (2) @(negedge clk);
    `CHK("pa_out", 8'h50, pa_out & 8'hf0)
    `CHK("pa_pullup", 8'h0f, pa_pu)
    sw_drive = 8'hf7;
    repeat (4) @(negedge clk);
    rchk(eio_pkg::ADDR_DATA, 8'h5b);
    sw_drive = 8'hff;
    wr(eio_pkg::ADDR_PULLUP, 8'h00);
    // Timer takes pins 5, 2, 1 and 0 in both polarities.
    wr(eio_pkg::ADDR_FUNC, 8'h55);
    for (int t = 0; t < 2; t++)
    begin
      t_out = t[0];
      t_inv = ~t[0];
      repeat (3) @(negedge clk);
      `CHK("pa_oe", 8'h27, pa_oe & 8'h27)
      `CHK("pa_out", (t != 0) ? 8'h05 : 8'h22, pa_out & 8'h27)
    end
    wr(eio_pkg::ADDR_FUNC, 8'h00);
    repeat (2) @(negedge clk);
    `CHK("pa_oe", 8'hf0, pa_oe)
    wr(eio_pkg::ADDR_DIR, 8'hff);
    sw_level = 8'hff;
    for (int i = 0; i < 4; i++)
    begin
      wr(eio_pkg::ADDR_REMAP, 8'(i));
      sw_level = ~(8'h01 << pins[i]);
      repeat (4) @(negedge clk);
      `CHK("ext_irq", 1'b0, irq)
      sw_level = 8'hff;
      repeat (4) @(negedge clk);
      `CHK("ext_irq", 1'b1, irq)
    end
    // Capture input follows pin 6 or pin 0, timer clock pin 7 or pin 6.
    sw_level = 8'hbf;
    wr(eio_pkg::ADDR_REMAP, 8'h00);
    repeat (4) @(negedge clk);
    `CHK("capt", 1'b0, capt)
    `CHK("tclk", 1'b1, tclk)
    wr(eio_pkg::ADDR_REMAP, 8'h30);
    repeat (2) @(negedge clk);
    `CHK("capt", 1'b1, capt)
    `CHK("tclk", 1'b0, tclk)
    sw_level = 8'hff;
    // Only enabled pins wake, and only while asleep.
    wr(eio_pkg::ADDR_WAKE, 8'h01);
    sleep = 1'b1;
    sw_level = 8'hfd;
    cnt_wake(c);
    `CHK("wake", 0, c)
    sw_level = 8'hfc;
    cnt_wake(c);
    `CHK("wake", 1, c)
    sleep = 1'b0;
    sw_level = 8'hff;
    repeat (4) @(negedge clk);
    sw_level = 8'hfe;
    cnt_wake(c);
    `CHK("wake", 0, c)
    sw_level = 8'hff;
    wr(eio_pkg::ADDR_DATA, 8'h00);
    wr(eio_pkg::ADDR_DIR, 8'h00);
    wr(eio_pkg::ADDR_PULLUP, 8'hff);
    wr(eio_pkg::ADDR_WAKE, 8'hff);
    wr(eio_pkg::ADDR_FUNC, 8'h55);
    wr(eio_pkg::ADDR_REMAP, 8'h33);
    @(negedge clk);
    sys_reset = 1'b1;
    @(negedge clk);
    sys_reset = 1'b0;
    repeat (2) @(negedge clk);
    reset_tab();
    close_out();
  end
endmodule : tb_eio_port
